// *** pkg/isp_pkg.sv ***
// Shared constants, types and helpers for the instruction scratchpad port.
package isp_pkg;
    // Register byte offsets.
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_ADDR = 8'h04;
    localparam logic [7:0] OFF_CMP = 8'h08;
    localparam logic [7:0] OFF_WDATA = 8'h0C;
    localparam logic [7:0] OFF_TAG_LOW_REGISTER = 8'h10;
    localparam logic [7:0] OFF_RDATA = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_TAGRD = 8'h1C;
    // Field positions.
    localparam int unsigned PA_MSB = 31;
    localparam int unsigned PA_LSB = 10;
    localparam int unsigned IDX_MSB = 19;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned LOCK_BIT = 1;
    localparam int unsigned VALID_BIT = 0;
    localparam int unsigned UNC_BIT = 0;
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_DONE_BIT = 1;
    localparam int unsigned ST_HIT_BIT = 2;
    localparam int unsigned ST_ATT_BIT = 3;
    // Reset word and response codes.
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Command codes: 0 data write, 1 tag write, 2 fetch, 3 tag load.
    typedef enum logic [1:0] {
        OP_DWRITE,
        OP_TWRITE,
        OP_FETCH,
        OP_TLOAD
    } isp_op_t;

    // Bus word with eight leading zeros, a physical tag and two low bits.
    function automatic logic [31:0] isp_word(input logic [21:0] pa,
                                             input logic b1,
                                             input logic b0);
        isp_word = {8'h00, pa, b1, b0};
    endfunction

    // Byte-lane merge for partial register writes.
    function automatic logic [31:0] isp_merge(input logic [31:0] old,
                                              input logic [31:0] nw,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        isp_merge = res;
    endfunction
endpackage

// *** pkg/isp_reg_if.sv ***
// Link between the register slave and the scratchpad port engine.
`timescale 1ns/1ns
interface isp_reg_if;
    logic cmd_go;
    logic [1:0] cmd_op;
    logic [17:0] vidx;
    logic [21:0] cmp_pa;
    logic cmp_unc;
    logic [31:0] wdata;
    logic tag_wr;
    logic [31:0] tag_wdata;
    logic busy;
    logic done;
    logic hit;
    logic attached;
    logic [31:0] rdata;
    logic [31:0] tag_low;
    logic [23:0] tag_rd;

    modport regs (
        output cmd_go, cmd_op, vidx, cmp_pa, cmp_unc, wdata, tag_wr,
        output tag_wdata,
        input busy, done, hit, attached, rdata, tag_low, tag_rd
    );
    modport core (
        input cmd_go, cmd_op, vidx, cmp_pa, cmp_unc, wdata, tag_wr,
        input tag_wdata,
        output busy, done, hit, attached, rdata, tag_low, tag_rd
    );
endinterface

// *** logic/isp_axil_regs.sv ***
// AXI4-Lite register slave for the instruction scratchpad port.
`timescale 1ns/1ns
module isp_axil_regs
    import isp_pkg::*;
(
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data.
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // Write response.
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read address and data.
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Engine side.
    isp_reg_if.regs rif
);
    logic aw_held_r, w_held_r, do_wr;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, addr_r, cmp_r, wdat_r;
    logic [3:0] w_strb_r;
    logic [1:0] op_r;

    assign awready = !aw_held_r && !bvalid;
    assign wready = !w_held_r && !bvalid;
    assign arready = !rvalid;
    assign do_wr = aw_held_r && w_held_r && !bvalid;

    // Address and data are latched in either order; the write acts once
    // both are present, so the response always follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= RST_WORD;
            w_strb_r <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= awaddr;
            end else if (do_wr) begin
                aw_held_r <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_r <= 1'b1;
                w_data_r <= wdata;
                w_strb_r <= wstrb;
            end else if (do_wr) begin
                w_held_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            case ({aw_addr_r[7:2], 2'b00})
                OFF_CMD, OFF_ADDR, OFF_CMP, OFF_WDATA, OFF_TAG_LOW_REGISTER,
                OFF_RDATA, OFF_STATUS, OFF_TAGRD: bresp <= RESP_OKAY;
                default: bresp <= RESP_SLVERR;
            endcase
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // A command written while the engine is busy is dropped; software
    // polls the busy bit before issuing the next one.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_r <= RST_WORD;
            cmp_r <= RST_WORD;
            wdat_r <= RST_WORD;
            op_r <= 2'h0;
            rif.cmd_go <= 1'b0;
            rif.tag_wr <= 1'b0;
            rif.tag_wdata <= RST_WORD;
        end else begin
            rif.cmd_go <= do_wr && ({aw_addr_r[7:2], 2'b00} == OFF_CMD)
                && w_strb_r[0] && !rif.busy;
            rif.tag_wr <= do_wr && ({aw_addr_r[7:2], 2'b00} == OFF_TAG_LOW_REGISTER);
            rif.tag_wdata <= isp_merge(rif.tag_low, w_data_r, w_strb_r);
            if (do_wr) begin
                case ({aw_addr_r[7:2], 2'b00})
                    OFF_CMD: if (w_strb_r[0] && !rif.busy) begin
                        op_r <= w_data_r[1:0];
                    end
                    OFF_ADDR: addr_r <= isp_merge(addr_r, w_data_r, w_strb_r);
                    OFF_CMP: cmp_r <= isp_merge(cmp_r, w_data_r, w_strb_r);
                    OFF_WDATA: wdat_r <= isp_merge(wdat_r, w_data_r, w_strb_r);
                    default: ;
                endcase
            end
        end
    end

    assign rif.cmd_op = op_r;
    assign rif.vidx = addr_r[IDX_MSB:IDX_LSB];
    assign rif.cmp_pa = cmp_r[PA_MSB:PA_LSB];
    assign rif.cmp_unc = cmp_r[UNC_BIT];
    assign rif.wdata = wdat_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= RST_WORD;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            case ({araddr[7:2], 2'b00})
                OFF_CMD: rdata <= {30'h0000_0000, op_r};
                OFF_ADDR: rdata <= addr_r;
                OFF_CMP: rdata <= cmp_r;
                OFF_WDATA: rdata <= wdat_r;
                OFF_TAG_LOW_REGISTER: rdata <= rif.tag_low;
                OFF_RDATA: rdata <= rif.rdata;
                OFF_STATUS: rdata <= {28'h000_0000, rif.attached, rif.hit,
                                      rif.done, rif.busy};
                OFF_TAGRD: rdata <= {8'h00, rif.tag_rd};
                default: begin
                    rdata <= RST_WORD;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// *** logic/isp_port.sv ***
// Instruction scratchpad port engine with its AXI4-Lite register slave.
//
// Contract
// - A data write puts the 32-bit store word on the write/compare bus.
// - A tag write drives zeros, PA[31:10], lock, valid from the tag-low reg.
// - A compare drives zeros, PA[31:10], the uncacheable flag and a zero bit.
// - The uncacheable flag is high for uncacheable space, low for cacheable.
// - The data write strobe marks the bus word for the data array.
// - The array returns PA, lock, valid; a tag load copies them to tag-low.
// - An 18-bit word index, address bits 19 to 2, goes with every access.
// - A read strobe reads tag and data; hit and stall answer that strobe.
// - With software tags, a tag write strobe marks when to store the tag.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ns
module isp_port
    import isp_pkg::*;
#(
    parameter bit TAG_WRITABLE = 1'b1
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_awaddr,
    input wire logic [2:0] s_awprot,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_araddr,
    input wire logic [2:0] s_arprot,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Scratchpad array side.
    output logic [17:0] scratch_word_index,
    output logic [31:0] write_compare_bus,
    output logic data_write_strobe,
    output logic tag_write_strobe,
    output logic scratch_read_strobe,
    input wire logic [31:0] data_read_word,
    input wire logic [23:0] tag_read_word,
    input wire logic scratch_hit,
    input wire logic scratch_stall,
    input wire logic scratch_attached
);
    typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} isp_state_t;

    isp_reg_if rif ();
    isp_state_t st_r;
    logic [1:0] op_r;
    logic att_meta_r, att_r;
    logic [31:0] tag_low_r, rdata_r;
    logic [23:0] tag_rd_r;
    logic hit_r, done_r, start, is_read, finish;

    isp_axil_regs u_regs (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_awaddr),
        .awvalid(s_awvalid),
        .awready(s_awready),
        .wdata(s_wdata),
        .wstrb(s_wstrb),
        .wvalid(s_wvalid),
        .wready(s_wready),
        .bresp(s_bresp),
        .bvalid(s_bvalid),
        .bready(s_bready),
        .araddr(s_araddr),
        .arvalid(s_arvalid),
        .arready(s_arready),
        .rdata(s_rdata),
        .rresp(s_rresp),
        .rvalid(s_rvalid),
        .rready(s_rready),
        .rif(rif.regs)
    );

    // The attached level is a static strap but still comes from a pin.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            att_meta_r <= 1'b0;
            att_r <= 1'b0;
        end else begin
            att_meta_r <= scratch_attached;
            att_r <= att_meta_r;
        end
    end

    assign start = (st_r == ST_IDLE) && rif.cmd_go;
    assign is_read = (op_r == OP_FETCH) || (op_r == OP_TLOAD);
    // Stall is only trusted from the cycle after the strobe.
    // wait on stall
    assign finish = (st_r == ST_WAIT) && !scratch_stall;

    // With no array attached a command completes at once with no strobe,
    // so software never hangs on a port that nothing answers.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= ST_IDLE;
            op_r <= 2'h0;
        end else begin
            case (st_r)
                ST_IDLE: if (start) begin
                    op_r <= rif.cmd_op;
                    st_r <= att_r ? ST_ISSUE : ST_IDLE;
                end
                ST_ISSUE: st_r <= is_read ? ST_WAIT : ST_IDLE;
                ST_WAIT: if (finish) begin
                    st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    // Strobes are one-cycle pulses; bus and index stay until the next job.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scratch_word_index <= 18'h0_0000;
            write_compare_bus <= RST_WORD;
            data_write_strobe <= 1'b0;
            tag_write_strobe <= 1'b0;
            scratch_read_strobe <= 1'b0;
        end else begin
            data_write_strobe <= 1'b0;
            tag_write_strobe <= 1'b0;
            scratch_read_strobe <= 1'b0;
            if (start && att_r) begin
                scratch_word_index <= rif.vidx;
                case (rif.cmd_op)
                    OP_DWRITE: begin
                        write_compare_bus <= rif.wdata;
                        data_write_strobe <= 1'b1;
                    end
                    OP_TWRITE: begin
                        write_compare_bus <= isp_word(
                            tag_low_r[PA_MSB:PA_LSB], tag_low_r[LOCK_BIT],
                            tag_low_r[VALID_BIT]);
                        tag_write_strobe <= TAG_WRITABLE;
                    end
                    default: begin
                        write_compare_bus <= isp_word(rif.cmp_pa,
                                                      rif.cmp_unc, 1'b0);
                        scratch_read_strobe <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Results are captured only in the finishing cycle; a command started while detached clears hit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_r <= RST_WORD;
            tag_rd_r <= 24'h00_0000;
            hit_r <= 1'b0;
        end else if (start && !att_r) begin
            hit_r <= 1'b0;
        end else if (finish) begin
            rdata_r <= data_read_word;
            tag_rd_r <= tag_read_word;
            hit_r <= scratch_hit;
        end
    end

    // A tag load from the array beats a software write in the same cycle.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tag_low_r <= RST_WORD;
        end else if (finish && (op_r == OP_TLOAD)) begin
            tag_low_r <= {tag_read_word[23:2], 8'h00,
                          tag_read_word[1], tag_read_word[0]};
        end else if (rif.tag_wr) begin
            tag_low_r <= rif.tag_wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_r <= 1'b0;
        end else if (finish || (st_r == ST_ISSUE && !is_read)
                     || (start && !att_r)) begin
            done_r <= 1'b1;
        end else if (start) begin
            done_r <= 1'b0;
        end
    end

    assign rif.busy = (st_r != ST_IDLE);
    assign rif.done = done_r;
    assign rif.hit = hit_r;
    assign rif.attached = att_r;
    assign rif.rdata = rdata_r;
    assign rif.tag_low = tag_low_r;
    assign rif.tag_rd = tag_rd_r;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_dwrite_word;
        data_write_strobe |-> write_compare_bus == $past(rif.wdata);
    endproperty
    a_dwrite_word: assert property (p_dwrite_word)
        else $error("data write word differs from store register");

    property p_twrite_word;
        tag_write_strobe |-> write_compare_bus == isp_word(
            $past(tag_low_r[31:10]), $past(tag_low_r[1]), $past(tag_low_r[0]));
    endproperty
    a_twrite_word: assert property (p_twrite_word)
        else $error("tag write word malformed");

    property p_cmp_word;
        scratch_read_strobe |-> write_compare_bus[31:24] == 8'h00
            && write_compare_bus[0] == 1'b0
            && write_compare_bus[23:2] == $past(rif.cmp_pa);
    endproperty
    a_cmp_word: assert property (p_cmp_word)
        else $error("compare word malformed");

    property p_unc_flag;
        scratch_read_strobe |-> write_compare_bus[1] == $past(rif.cmp_unc);
    endproperty
    a_unc_flag: assert property (p_unc_flag)
        else $error("uncacheable flag wrong");

    property p_dstrobe_pulse;
        data_write_strobe |=> !data_write_strobe && !scratch_read_strobe;
    endproperty
    a_dstrobe_pulse: assert property (p_dstrobe_pulse)
        else $error("data write strobe longer than one cycle");

    property p_tag_load;
        finish && op_r == OP_TLOAD |=> tag_low_r[31:10] ==
            $past(tag_read_word[23:2]) && tag_low_r[1:0] ==
            $past(tag_read_word[1:0]);
    endproperty
    a_tag_load: assert property (p_tag_load)
        else $error("tag load did not copy tag read word");

    property p_index;
        (data_write_strobe || tag_write_strobe || scratch_read_strobe)
            |-> scratch_word_index == $past(rif.vidx);
    endproperty
    a_index: assert property (p_index)
        else $error("word index not taken from address register");

    property p_read_issue;
        start && att_r && rif.cmd_op[1] |=> scratch_read_strobe
            ##1 st_r == ST_WAIT;
    endproperty
    a_read_issue: assert property (p_read_issue)
        else $error("read command did not strobe and wait");

    property p_tag_gate;
        tag_write_strobe |-> TAG_WRITABLE && $past(att_r);
    endproperty
    a_tag_gate: assert property (p_tag_gate)
        else $error("tag write strobe while tags are fixed");

    property p_stall_hold;
        st_r == ST_WAIT && scratch_stall |=> st_r == ST_WAIT && !done_r;
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("read finished while stall was high");

    c_dwrite: cover property (data_write_strobe);
    c_twrite: cover property (tag_write_strobe);
    c_stalled_fetch: cover property (
        scratch_read_strobe ##1 scratch_stall [*2] ##1 !scratch_stall);
    c_tag_load: cover property (finish && op_r == OP_TLOAD);
endmodule

// *** tb/isp_array_model.sv ***
// Behavioural scratchpad array that answers the port's strobes.
`timescale 1ns/1ns
module isp_array_model (
    // Clock and stall length.
    input wire logic aclk,
    input wire logic [3:0] lat,
    // From the port.
    input wire logic [17:0] scratch_word_index,
    input wire logic [31:0] write_compare_bus,
    input wire logic data_write_strobe,
    input wire logic tag_write_strobe,
    input wire logic scratch_read_strobe,
    // To the port.
    output logic [31:0] data_read_word,
    output logic [23:0] tag_read_word,
    output logic scratch_hit,
    output logic scratch_stall
);
    logic [31:0] mem [16];
    logic [23:0] tag [16];
    logic [3:0] cnt_r = 4'h0;
    logic rd_r = 1'b0;
    logic [21:0] pa_r = 22'h00_0000;
    logic ok;
    logic match;
    logic [3:0] a;
    assign a = scratch_word_index[3:0];
    assign ok = rd_r && cnt_r == 4'h0;
    assign match = tag[a][23:2] == pa_r && tag[a][0];
    assign scratch_stall = rd_r && cnt_r != 4'h0;
    // Results are inverted while not valid, so an early capture shows.
    // read words
    assign data_read_word = ok ? mem[a] : ~mem[a];
    assign tag_read_word = ok ? tag[a] : ~tag[a];
    assign scratch_hit = ok ? match : !match;
    always @(posedge aclk) begin
        if (data_write_strobe) mem[a] <= write_compare_bus;
        if (tag_write_strobe) tag[a] <= write_compare_bus[23:0];
        if (scratch_read_strobe) begin
            rd_r <= 1'b1;
            cnt_r <= lat;
            pa_r <= write_compare_bus[23:2];
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end else begin
            rd_r <= 1'b0;
        end
    end
endmodule

// *** tb/test_instr_scratchpad_port.sv ***
// Self-checking bench for the instruction scratchpad port.
`timescale 1ns/1ns
module test_instr_scratchpad_port;
    import isp_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [2:0] s_awprot = 3'h0, s_arprot = 3'h0;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0] s_wstrb = 4'hF;
    logic [3:0] lat = 4'h0;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic s_arvalid = 1'b0, s_rready = 1'b0, scratch_attached = 1'b1;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata, write_compare_bus, data_read_word;
    logic [17:0] scratch_word_index;
    logic [23:0] tag_read_word;
    logic data_write_strobe, tag_write_strobe, scratch_read_strobe;
    logic scratch_hit, scratch_stall;
    int fails = 0, num_checks = 0, n_rs = 0, n_dw = 0, n_tw = 0;
    localparam logic [31:0] ADDR = 32'h000A_BCD4;
    localparam logic [31:0] WORD = 32'h1234_5678;
    localparam logic [31:0] TL = 32'h8765_4FFF;

    isp_port dut (.aclk, .aresetn, .s_awaddr, .s_awprot, .s_awvalid,
        .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
        .s_bvalid, .s_bready, .s_araddr, .s_arprot, .s_arvalid, .s_arready,
        .s_rdata, .s_rresp, .s_rvalid, .s_rready, .scratch_word_index,
        .write_compare_bus, .data_write_strobe, .tag_write_strobe,
        .scratch_read_strobe, .data_read_word, .tag_read_word, .scratch_hit,
        .scratch_stall, .scratch_attached);
    isp_array_model array (.aclk, .lat, .scratch_word_index,
        .write_compare_bus, .data_write_strobe, .tag_write_strobe,
        .scratch_read_strobe, .data_read_word, .tag_read_word, .scratch_hit,
        .scratch_stall);

    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        if (scratch_read_strobe === 1'b1) n_rs++;
        if (data_write_strobe === 1'b1) n_dw++;
        if (tag_write_strobe === 1'b1) n_tw++;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("Error at %0t: %s got %h want %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        r = 2'h3;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        // No cycle budget here; only the watchdog ends a hung transfer.
        forever begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_bvalid) begin
                r = s_bresp;
                break;
            end
        end
        s_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        r = 2'h3;
        d = 32'h0000_0000;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) begin
                d = s_rdata;
                r = s_rresp;
                break;
            end
        end
        s_rready <= 1'b0;
    endtask

    task automatic job(input isp_op_t op, output logic [31:0] st);
        logic [1:0] r;
        wr(OFF_CMD, 32'(op), r);
        st = 32'h0000_0001;
        for (int n = 0; n < 40 && st[1:0] !== 2'b10; n++)
            rd(OFF_STATUS, st, r);
        chk(st[1:0], 2'b10, "job end");
    endtask

    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        chk(write_compare_bus, 32'h0000_0000, "idle bus");
        chk({14'h0000, scratch_word_index}, 32'h0000_0000, "idle index");
        chk({29'h0000_0000, data_write_strobe, tag_write_strobe,
             scratch_read_strobe}, 32'h0000_0000, "idle strobes");
        rd(OFF_STATUS, d, r);
        chk(d, 32'h0000_0008, "status");
        $display("reset test ended");
    endtask

    task automatic t_dwrite();
        logic [31:0] st;
        logic [1:0] r;
        int n;
        n = n_dw;
        wr(OFF_ADDR, ADDR, r);
        wr(OFF_WDATA, WORD, r);
        chk({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY}, "write resp");
        job(OP_DWRITE, st);
        chk(n_dw, n + 1, "data strobes");
        chk(write_compare_bus, WORD, "store word");
        chk(scratch_word_index, ADDR[19:2], "index");
        $display("data write test ended");
    endtask

    task automatic t_twrite();
        logic [31:0] st;
        logic [1:0] r;
        int n;
        n = n_tw;
        wr(OFF_TAG_LOW_REGISTER, TL, r);
        job(OP_TWRITE, st);
        chk(n_tw, n + 1, "tag strobes");
        chk(write_compare_bus, {8'h00, TL[31:10], TL[1:0]}, "tag word");
        $display("tag write test ended");
    endtask

    task automatic t_fetch(input logic [21:0] pa, input logic unc,
                           input logic [3:0] l, input logic h);
        logic [31:0] st;
        logic [31:0] d;
        logic [1:0] r;
        int n;
        n = n_rs;
        lat <= l;
        wr(OFF_CMP, {pa, 9'h000, unc}, r);
        job(OP_FETCH, st);
        chk(n_rs, n + 1, "read strobes");
        chk(write_compare_bus, {8'h00, pa, unc, 1'b0}, "compare");
        chk(st[ST_HIT_BIT], h, "hit");
        rd(OFF_RDATA, d, r);
        chk(d, WORD, "read word");
        $display("fetch test ended");
    endtask

    task automatic t_tload();
        logic [31:0] st;
        logic [31:0] d;
        logic [1:0] r;
        wr(OFF_TAG_LOW_REGISTER, 32'h0000_0000, r);
        lat <= 4'h2;
        job(OP_TLOAD, st);
        rd(OFF_TAG_LOW_REGISTER, d, r);
        chk(d & 32'hFFFF_FC03, TL & 32'hFFFF_FC03, "tag load");
        rd(OFF_TAGRD, d, r);
        chk(d, {8'h00, TL[31:10], TL[1:0]}, "tag read");
        $display("tag load test ended");
    endtask

    task automatic t_unmapped();
        logic [31:0] d;
        logic [1:0] r;
        wr(8'h20, WORD, r);
        chk(r, RESP_SLVERR, "write resp");
        rd(8'h20, d, r);
        chk(d, 32'h0000_0000, "read data");
        chk({30'h0000_0000, r}, {30'h0000_0000, RESP_SLVERR}, "read resp");
        $display("unmapped test ended");
    endtask

    task automatic t_detached();
        logic [31:0] st;
        int n;
        scratch_attached <= 1'b0;
        repeat (4) @(posedge aclk);
        n = n_rs;
        job(OP_FETCH, st);
        chk(n_rs, n, "no strobe");
        chk(st[3:2], 2'b00, "no hit, detached");
        scratch_attached <= 1'b1;
        repeat (4) @(posedge aclk);
        $display("detached test ended");
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        t_reset();
        t_dwrite();
        t_twrite();
        t_fetch(TL[31:10], 1'b1, 4'h3, 1'b1);
        t_fetch(TL[31:10], 1'b0, 4'h0, 1'b1);
        t_fetch(22'h15_5555, 1'b0, 4'h1, 1'b0);
        t_tload();
        t_unmapped();
        t_detached();
        test_done();
    end

    // The whole sequence needs well under two thousand cycles.
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end
endmodule
